//--- core/cwt_calendar_timers.sv
// cwt_calendar_timers: four weekday/calendar timers with Avalon-MM register access
//
// Summary of operation
// R1: four independent timers, each own settings, output
// R2: output on at on-time, off at off-time
// R3: twelve day-selection modes per timer
// R4: not-in-use timer idles, output held 0
// R5: daily mode switches every calendar day
// R6: single-weekday mode switches only that day
// R7: weekdays mode skips Saturday and Sunday
// R8: weekdays-and-Saturday mode skips Sunday only
// R9: weekend mode switches Saturday and Sunday only
// R10: status reads unused/0/1; force only in use
// R11: status write sets output at once
// R12: forced state holds until write or reversing act
// R13: save statuses to storage on power loss
// R14: restore statuses from storage before scheduling
// R15: outputs feed logic and output matrix
// R16: compare time once per second tick
`timescale 1ns/10ps

module cwt_calendar_timers
    import cwt_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    // system real-time clock, same domain
    input  wire logic                sec_tick,
    input  wire logic [HOUR_W-1:0]   tod_hour,
    input  wire logic [MIN_W-1:0]    tod_min,
    input  wire logic [SEC_W-1:0]    tod_sec,
    input  wire logic [2:0]          weekday,
    // power supervision pin, asynchronous
    input  wire logic                aux_power_lost,
    // non-volatile status store
    input  wire logic                nv_valid,
    input  wire logic [TIMERS-1:0]   nv_state,
    output logic                     nv_save,
    output logic      [TIMERS-1:0]   nv_save_state,
    // timer outputs to programmable logic and output matrix
    output logic      [TIMERS-1:0]   calendar_timer_state
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [TIMERS-1:0][TOD_W-1:0] on_t;
        logic [TIMERS-1:0][TOD_W-1:0] off_t;
        logic [TIMERS-1:0][3:0]       mode;
        logic [TIMERS-1:0]            state;
        logic [TIMERS-1:0]            out;
        logic                         restored;
        logic [1:0]                   pf_sync;
        logic                         pf_prev;
        logic                         save;
        logic [TIMERS-1:0]            save_state;
        logic                         wait_n;
        logic                         req_wait;
        logic [DATA_W-1:0]            rdata;
    } cwt_state_s;

    cwt_state_s st_r;
    cwt_state_s st_nxt;

    cwt_tod_t          now;
    logic [TIMERS-1:0] in_use;
    logic [TIMERS-1:0] day_hit;
    logic [TIMERS-1:0] on_hit;
    logic [TIMERS-1:0] off_hit;
    logic [1:0]        sel_tmr;
    logic [3:0]        sel_reg;
    logic              mapped;
    logic              bus_go;
    logic [DATA_W-1:0] be_mask;

    assign now     = {tod_hour, tod_min, tod_sec};
    assign sel_tmr = avs_address[5:4];
    assign sel_reg = avs_address[3:0];
    assign mapped  = (avs_address < MAP_END);
    // request executes on the edge where waitrequest is seen low
    assign bus_go  = (avs_read || avs_write) && st_r.wait_n;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic day_selected(input logic [3:0] m, input logic [2:0] d);
        logic r;
        r = 1'b0;
        case (m)
            CWT_DAILY:                  r = 1'b1;                       // R5
            CWT_MONDAY, CWT_TUESDAY, CWT_WEDNESDAY, CWT_THURSDAY,
            CWT_FRIDAY, CWT_SATURDAY, CWT_SUNDAY:
                r = (d == 3'(m - CWT_MONDAY));                          // R6
            WEEKDAYS_ONLY_MODE:         r = (d <= DAY_FRI);             // R7
            WEEKDAYS_AND_SATURDAY_MODE: r = (d <= DAY_SAT);             // R8
            WEEKEND_ONLY_MODE:          r = (d == DAY_SAT) || (d == DAY_SUN); // R9
            default:                    r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] tod_word(input cwt_tod_t t);
        logic [DATA_W-1:0] w;
        w = '0;
        w[HOUR_LSB +: HOUR_W] = t[SEC_W+MIN_W +: HOUR_W];
        w[MIN_LSB  +: MIN_W]  = t[SEC_W +: MIN_W];
        w[SEC_LSB  +: SEC_W]  = t[0 +: SEC_W];
        return w;
    endfunction

    function automatic cwt_tod_t word_tod(input logic [DATA_W-1:0] w);
        return {w[HOUR_LSB +: HOUR_W], w[MIN_LSB +: MIN_W], w[SEC_LSB +: SEC_W]};
    endfunction

    // ************************************************************
    // per-timer match logic
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < TIMERS; gi++) begin : g_tmr                          // R1
            // codes above the last mode count as not in use
            assign in_use[gi]  = (st_r.mode[gi] != CWT_NOT_IN_USE) &&
                                 (st_r.mode[gi] <= WEEKEND_ONLY_MODE);         // R3
            assign day_hit[gi] = day_selected(st_r.mode[gi], weekday);
            // compare only on the one-second tick, so each act fires once
            assign on_hit[gi]  = sec_tick && st_r.restored && in_use[gi] &&
                                 day_hit[gi] && (now == st_r.on_t[gi]);      // R16 R2
            assign off_hit[gi] = sec_tick && st_r.restored && in_use[gi] &&
                                 day_hit[gi] && (now == st_r.off_t[gi]);     // R16 R2
        end
    endgenerate

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [DATA_W-1:0] merged;
        logic [TIMERS-1:0] use_nxt;
        merged = '0;
        use_nxt = '0;
        st_nxt = st_r;
        st_nxt.save = 1'b0;

        // power-loss detection; first stage feeds only the second
        st_nxt.pf_sync = {st_r.pf_sync[0], aux_power_lost};
        st_nxt.pf_prev = st_r.pf_sync[1];
        if (st_r.pf_sync[1] && !st_r.pf_prev) begin
            st_nxt.save       = 1'b1;                                        // R13
            st_nxt.save_state = st_r.state;                                  // R13
        end

        // restore the stored statuses once before the schedule runs
        if (!st_r.restored && nv_valid) begin
            st_nxt.state    = nv_state;                                      // R14
            st_nxt.restored = 1'b1;                                          // R14
        end

        // schedule; off wins when on and off times are equal
        for (int i = 0; i < TIMERS; i++) begin
            if (on_hit[i]) begin
                st_nxt.state[i] = 1'b1;                                      // R2 R12
            end
            if (off_hit[i]) begin
                st_nxt.state[i] = 1'b0;                                      // R2 R12
            end
        end

        // bus slave: one wait cycle, then the request completes
        st_nxt.wait_n = 1'b0;
        if ((avs_read || avs_write) && !st_r.wait_n) begin
            st_nxt.wait_n = 1'b1;
            st_nxt.rdata  = '0;
            if (mapped) begin
                unique case (sel_reg)
                    OFS_ON:    st_nxt.rdata = tod_word(st_r.on_t[sel_tmr]);
                    OFS_OFF:   st_nxt.rdata = tod_word(st_r.off_t[sel_tmr]);
                    OFS_MODE:  st_nxt.rdata = DATA_W'(st_r.mode[sel_tmr]);
                    OFS_STATE: st_nxt.rdata = !in_use[sel_tmr] ? DATA_W'(STAT_UNUSED) :
                                              st_r.state[sel_tmr] ? DATA_W'(STAT_ACTIVE) :
                                              DATA_W'(STAT_INACTIVE);           // R10
                    default:   st_nxt.rdata = '0;
                endcase
            end
        end

        // waitrequest kept as its own flop so the port needs no inverter
        st_nxt.req_wait = !st_nxt.wait_n;

        // a write comes last so it overrides a same-cycle timed act
        if (bus_go && avs_write && mapped) begin
            unique case (sel_reg)
                OFS_ON: begin
                    merged = (tod_word(st_r.on_t[sel_tmr]) & ~be_mask) |
                             (avs_writedata & be_mask);
                    st_nxt.on_t[sel_tmr] = word_tod(merged);
                end
                OFS_OFF: begin
                    merged = (tod_word(st_r.off_t[sel_tmr]) & ~be_mask) |
                             (avs_writedata & be_mask);
                    st_nxt.off_t[sel_tmr] = word_tod(merged);
                end
                OFS_MODE: begin
                    if (avs_byteenable[0]) begin
                        st_nxt.mode[sel_tmr] = avs_writedata[3:0];
                    end
                end
                OFS_STATE: begin
                    // force needs byte 0 enabled; ignored while not in use
                    if (avs_byteenable[0] && in_use[sel_tmr]) begin
                        st_nxt.state[sel_tmr] = avs_writedata[0];           // R10 R11
                    end
                end
                default: begin
                end
            endcase
        end

        // output follows status, held low when not in use
        for (int i = 0; i < TIMERS; i++) begin
            use_nxt[i] = (st_nxt.mode[i] != CWT_NOT_IN_USE) &&
                         (st_nxt.mode[i] <= WEEKEND_ONLY_MODE);
        end
        st_nxt.out = st_nxt.state & use_nxt;                                 // R4 R15
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.pf_sync <= SYNC_RST;
            st_r.req_wait <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata         = st_r.rdata;
    assign avs_waitrequest      = st_r.req_wait;
    assign nv_save              = st_r.save;
    assign nv_save_state        = st_r.save_state;
    assign calendar_timer_state = st_r.out;                                  // R15

endmodule

//--- core/cwt_pkg.sv
// cwt_pkg: constants, register map and types of the calendar weekday timers
package cwt_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int TIMERS   = 4;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // ************************************************************
    // register map, byte addresses; timer n sits at n * TMR_STRIDE
    // ************************************************************
    localparam logic [ADDR_W-1:0] TMR_STRIDE = 8'h10;
    localparam logic [3:0]        OFS_ON     = 4'h0;
    localparam logic [3:0]        OFS_OFF    = 4'h4;
    localparam logic [3:0]        OFS_MODE   = 4'h8;
    localparam logic [3:0]        OFS_STATE  = 4'hC;
    localparam logic [ADDR_W-1:0] MAP_END    = 8'h40;

    // time word layout: hour, minute, second
    localparam int SEC_LSB  = 0;
    localparam int MIN_LSB  = 8;
    localparam int HOUR_LSB = 16;
    localparam int SEC_W    = 6;
    localparam int MIN_W    = 6;
    localparam int HOUR_W   = 5;
    localparam int TOD_W    = HOUR_W + MIN_W + SEC_W;

    // readable timer status codes
    localparam logic [1:0] STAT_INACTIVE = 2'h0;
    localparam logic [1:0] STAT_ACTIVE   = 2'h1;
    localparam logic [1:0] STAT_UNUSED   = 2'h2;

    // weekday numbering of the clock input
    localparam logic [2:0] DAY_MON = 3'h0;
    localparam logic [2:0] DAY_FRI = 3'h4;
    localparam logic [2:0] DAY_SAT = 3'h5;
    localparam logic [2:0] DAY_SUN = 3'h6;

    localparam logic [1:0] SYNC_RST = 2'h0;

    typedef enum logic [3:0] {
        CWT_NOT_IN_USE           = 4'h0,
        CWT_DAILY                = 4'h1,
        CWT_MONDAY               = 4'h2,
        CWT_TUESDAY              = 4'h3,
        CWT_WEDNESDAY            = 4'h4,
        CWT_THURSDAY             = 4'h5,
        CWT_FRIDAY               = 4'h6,
        CWT_SATURDAY             = 4'h7,
        CWT_SUNDAY               = 4'h8,
        WEEKDAYS_ONLY_MODE       = 4'h9,
        WEEKDAYS_AND_SATURDAY_MODE = 4'hA,
        WEEKEND_ONLY_MODE        = 4'hB
    } cwt_mode_e;

    typedef logic [TOD_W-1:0] cwt_tod_t;

endpackage

//--- tb/cwt_calendar_timers_chk.sv
// checker: bus, save and output timing of the calendar timers
`timescale 1ns/10ps
module cwt_calendar_timers_chk
    import cwt_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              sec_tick,
    input wire logic              aux_power_lost,
    input wire logic              nv_valid,
    input wire logic              nv_save,
    input wire logic [TIMERS-1:0] nv_save_state,
    input wire logic [TIMERS-1:0] calendar_timer_state
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_one_wait: assert property (s_req |=> s_ans)
        else $error("bus answer timing wrong");
    a_no_idle_ans: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address >= MAP_END
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved between answers");
    a_save_delay: assert property ($rose(aux_power_lost) |-> ##[2:4] nv_save)
        else $error("no save after power loss");
    a_save_pulse: assert property (nv_save |=> !nv_save)
        else $error("save pulse too long");
    a_save_hold: assert property (!nv_save |-> $stable(nv_save_state))
        else $error("saved status moved");
    a_out_cause: assert property ($changed(calendar_timer_state) |-> $past(sec_tick)
        || $past(avs_write && !avs_waitrequest) || ($past(nv_valid) && !$past(nv_valid, 2)))
        else $error("output changed without cause");
endmodule

bind cwt_calendar_timers cwt_calendar_timers_chk chk_u (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .sec_tick, .aux_power_lost,
    .nv_valid, .nv_save, .nv_save_state, .calendar_timer_state);

//--- tb/cwt_calendar_timers_tb_top.sv
// testbench: bus-driven checks of the calendar timer block
`timescale 1ns/10ps
module cwt_calendar_timers_tb_top
    import cwt_pkg::*;
;
    logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic        sec_tick = 0, aux_power_lost = 0, avs_waitrequest, nv_valid, nv_save;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
    logic [4:0]  tod_hour = 5'h00;
    logic [5:0]  tod_min = 6'h00, tod_sec = 6'h00;
    logic [2:0]  weekday = 3'h0;
    logic [3:0]  nv_state, nv_save_state, calendar_timer_state;
    int          err_total = 0, cmp_count = 0, n, m, d;

    cwt_calendar_timers dut_u (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .sec_tick,
        .tod_hour, .tod_min, .tod_sec, .weekday, .aux_power_lost, .nv_valid,
        .nv_state, .nv_save, .nv_save_state, .calendar_timer_state);
    cwt_nv_store_model nv_u (.mclk, .rst_n, .nv_save, .nv_save_state, .nv_valid, .nv_state);

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int k;
        k = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= v;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        if (k == 50) err_total++;
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic tick(input logic [4:0] h, input logic [5:0] mi, input logic [2:0] wd);
        tod_hour <= h;
        tod_min <= mi;
        weekday <= wd;
        sec_tick <= 1'b1;
        @(posedge mclk);
        sec_tick <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic sel(input logic [3:0] md, input logic [2:0] wd);
        return md == 4'h1 || (md >= 4'h2 && md <= 4'h8 && wd == md[2:0] - 3'h2)
            || (md == 4'h9 && wd <= DAY_FRI) || (md == 4'hA && wd <= DAY_SAT)
            || (md == 4'hB && wd >= DAY_SAT);
    endfunction
    task automatic restore();
        n = 0;
        while (nv_valid !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial forever #50 mclk = ~mclk;
    initial begin
        #4000000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        chk("outputs", 32'h0, {28'h0, calendar_timer_state});
        restore();
        bus(1, 8'h08, 32'h1);
        chk("restored", 32'h1, {28'h0, calendar_timer_state});
        bus(0, 8'h0C, 32'h0);
        chk("status0", {30'h0, STAT_ACTIVE}, rdat);
        bus(1, 8'h1C, 32'h1);
        bus(0, 8'h1C, 32'h0);
        chk("status1", {30'h0, STAT_UNUSED}, rdat);
        bus(0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rdat);
        bus(1, 8'h10, 32'h0001_0000);
        bus(1, 8'h14, 32'h0002_0000);
        for (m = 0; m < 12; m++) begin
            bus(1, 8'h18, m);
            bus(1, 8'h1C, 32'h0);
            for (d = 0; d < 7; d++) begin
                tick(5'h01, 6'h00, d[2:0]);
                chk("on act", {30'h0, sel(m[3:0], d[2:0]), 1'b1}, calendar_timer_state);
                tick(5'h02, 6'h00, d[2:0]);
                chk("off act", 32'h1, {28'h0, calendar_timer_state});
            end
        end
        bus(1, 8'h30, 32'h0001_0000);
        bus(1, 8'h34, 32'h0002_0000);
        bus(1, 8'h38, 32'h1);
        bus(1, 8'h3C, 32'h1);
        chk("forced", 32'h9, {28'h0, calendar_timer_state});
        tick(5'h01, 6'h1E, 3'h0);
        chk("held", 32'h9, {28'h0, calendar_timer_state});
        tick(5'h02, 6'h00, 3'h0);
        chk("reversed", 32'h1, {28'h0, calendar_timer_state});
        bus(1, 8'h3C, 32'h1);
        tick(5'h01, 6'h00, 3'h0);
        chk("same act", 32'h9, {28'h0, calendar_timer_state});
        bus(1, 8'h20, 32'h0003_0007);
        bus(1, 8'h28, 32'h1);
        tod_sec <= 6'h06;
        tick(5'h03, 6'h00, 3'h0);
        chk("sec early", 32'h9, {28'h0, calendar_timer_state});
        tod_sec <= 6'h07;
        tick(5'h03, 6'h00, 3'h0);
        chk("sec match", 32'hD, {28'h0, calendar_timer_state});
        aux_power_lost <= 1'b1;
        n = 0;
        while (nv_save !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        chk("saved", 32'hD, {28'h0, nv_save_state});
        rst_n <= 1'b0;
        aux_power_lost <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        restore();
        bus(1, 8'h38, 32'h1);
        chk("round trip", 32'h8, {28'h0, calendar_timer_state});
        summarize();
    end
endmodule

//--- tb/cwt_nv_store_model.sv
// non-volatile status store: keeps saved statuses across resets, answers late
`timescale 1ns/10ps
module cwt_nv_store_model
    import cwt_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              nv_save,
    input wire logic [TIMERS-1:0] nv_save_state,
    output logic                  nv_valid,
    output logic [TIMERS-1:0]     nv_state
);
    logic [TIMERS-1:0] mem_r = 4'h1;
    logic [3:0]        cnt_r;
    // contents are never reset, like the real store
    always_ff @(posedge mclk) begin
        if (nv_save) mem_r <= nv_save_state;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= 4'h0;
            nv_valid <= 1'b0;
        end else begin
            if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
            nv_valid <= (cnt_r == 4'hF);
        end
    end
    // data is meaningless until valid, so show the inverse
    assign nv_state = nv_valid ? mem_r : ~mem_r;
endmodule
